/* hw/twm_pkg.sv */
// twm_pkg: offsets, field layout, types and mode decoding of the waveform timer
package twm_pkg;

	// ==========================================================
	// register offsets on the byte-wide register port
	localparam logic [7:0] WAVE_CTRL_ADDR = 8'h80;
	localparam logic [7:0] SECOND_CTRL_ADDR = 8'h81;
	localparam logic [7:0] CNT_LO_ADDR = 8'h84;
	localparam logic [7:0] CNT_HI_ADDR = 8'h85;
	localparam logic [7:0] CAP_LO_ADDR = 8'h86;
	localparam logic [7:0] CAP_HI_ADDR = 8'h87;
	localparam logic [7:0] CMPA_LO_ADDR = 8'h88;
	localparam logic [7:0] CMPA_HI_ADDR = 8'h89;
	localparam logic [7:0] CMPB_LO_ADDR = 8'h8a;
	localparam logic [7:0] CMPB_HI_ADDR = 8'h8b;
	localparam logic [7:0] STATUS_ADDR = 8'h8c;

	// ==========================================================
	// field positions
	localparam int ACT_A_POS = 6;
	localparam int ACT_B_POS = 4;
	localparam int MODE_LO_POS = 0;
	localparam int MODE_HI_POS = 3;
	localparam int CSEL_POS = 0;
	localparam int ST_OVF_POS = 0;
	localparam int ST_MATCH_A_POS = 1;
	localparam int ST_MATCH_B_POS = 2;

	// ==========================================================
	// values after reset and counter limits
	localparam logic [1:0] ACT_RESET = 2'h0;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [2:0] CSEL_RESET = 3'h0;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] TOP_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;

	// ==========================================================
	// prescaler: divider width and tap widths for /8 /64 /256 /1024
	localparam int PRE_W = 10;
	localparam int PRE_SH_8 = 3;
	localparam int PRE_SH_64 = 6;
	localparam int PRE_SH_256 = 8;
	localparam int PRE_SH_1024 = 10;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		CLS_NONPWM = 2'b00,
		CLS_FAST = 2'b01,
		CLS_DUAL = 2'b10
	} twm_class_e;

	typedef enum logic [1:0] {
		TSRC_FIXED = 2'b00,
		TSRC_CAPTURE = 2'b01,
		TSRC_CMPA = 2'b10
	} twm_top_e;

	typedef enum logic [1:0] {
		PT_NOW = 2'b00,
		PT_TOP = 2'b01,
		PT_BOTTOM = 2'b10,
		PT_MAX = 2'b11
	} twm_point_e;

	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} twm_dir_e;

	// ==========================================================
	// mode decoding
	function automatic twm_class_e mode_class(input logic [3:0] mode);
		if (mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}) begin
			return CLS_FAST;
		end
		if (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb}) begin
			return CLS_DUAL;
		end
		return CLS_NONPWM;
	endfunction

	function automatic twm_top_e top_source(input logic [3:0] mode);
		if (mode inside {4'h4, 4'h9, 4'hb, 4'hf}) begin
			return TSRC_CMPA;
		end
		if (mode inside {4'h8, 4'ha, 4'hc, 4'he}) begin
			return TSRC_CAPTURE;
		end
		return TSRC_FIXED;
	endfunction

	function automatic logic [15:0] fixed_top(input logic [3:0] mode);
		logic [15:0] t;
		t = TOP_MAX;
		if (!mode[3]) begin
			unique case (mode[1:0])
				2'h0: t = TOP_MAX;
				2'h1: t = TOP_8BIT;
				2'h2: t = TOP_9BIT;
				2'h3: t = TOP_10BIT;
			endcase
		end
		return t;
	endfunction

	function automatic twm_point_e update_point(input logic [3:0] mode);
		if (mode inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb}) begin
			return PT_TOP;
		end
		if (mode inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'he, 4'hf}) begin
			return PT_BOTTOM;
		end
		return PT_NOW;
	endfunction

	function automatic twm_point_e flag_point(input logic [3:0] mode);
		if (mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}) begin
			return PT_TOP;
		end
		if (mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb}) begin
			return PT_BOTTOM;
		end
		return PT_MAX;
	endfunction

	// toggle on action 01 is allowed in non-pwm modes and, for channel a, in pwm modes 9, 11, 14 and 15
	function automatic logic toggle_allowed(input logic [3:0] mode);
		return (mode inside {4'h9, 4'hb, 4'he, 4'hf}) || (mode_class(mode) == CLS_NONPWM);
	endfunction

	// replace one byte of a 16-bit word
	function automatic logic [15:0] set_byte(input logic [15:0] w, input logic hi,
		input logic [7:0] d);
		return hi ? {d, w[7:0]} : {w[15:8], d};
	endfunction

endpackage

/* hw/twm_prescaler.sv */
// twm_prescaler: count-enable tick from divided clock or external pin edge
`timescale 1ns/100ps
module twm_prescaler
	import twm_pkg::*;
#(
	parameter int DIV_W = PRE_W
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// selection and pin
	input wire logic [2:0] clock_select_in,
	input wire logic ext_pin_in,
	// tick
	output logic tick_out
);

	if (DIV_W < PRE_SH_1024) begin : g_div_chk
		$error("prescaler divider too narrow for the largest division");
	end

	logic [DIV_W-1:0] div_reg;
	logic pin_prev_reg;

	// ==========================================================
	// free running divider and pin history
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_reg <= '0;
			pin_prev_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 1'b1;
			pin_prev_reg <= ext_pin_in;
		end
	end

	// ==========================================================
	// tick selection, one cycle long
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_out <= 1'b0;
		end else begin
			unique case (clock_select_in)
				3'h0: tick_out <= 1'b0;
				3'h1: tick_out <= 1'b1;
				3'h2: tick_out <= &div_reg[PRE_SH_8-1:0];
				3'h3: tick_out <= &div_reg[PRE_SH_64-1:0];
				3'h4: tick_out <= &div_reg[PRE_SH_256-1:0];
				3'h5: tick_out <= &div_reg[PRE_SH_1024-1:0];
				3'h6: tick_out <= pin_prev_reg & ~ext_pin_in; // falling edge
				3'h7: tick_out <= ~pin_prev_reg & ext_pin_in; // rising edge
			endcase
		end
	end

endmodule

/* hw/twm_wave_channel.sv */
// twm_wave_channel: output action logic and pin control of one compare channel
`timescale 1ns/100ps
module twm_wave_channel
	import twm_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// counter events
	input wire logic tick_in,
	input wire logic match_in,
	input wire logic at_top_in,
	input wire logic heading_up_in,
	// configuration
	input wire logic [1:0] action_in,
	input wire twm_class_e cls_in,
	input wire logic toggle_ok_in,
	input wire logic dir_in,
	// pin
	output logic wave_out,
	output logic drive_en_out,
	output logic takeover_out
);

	logic connected;

	// action 01 without toggle permission leaves the pin disconnected
	assign connected = (action_in != 2'h0) && !(action_in == 2'h1 && !toggle_ok_in);

	// ==========================================================
	// waveform level
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wave_out <= 1'b0;
		end else if (tick_in) begin
			unique case (cls_in)
				CLS_NONPWM: begin
					if (match_in && action_in == 2'h1) begin
						wave_out <= ~wave_out;
					end else if (match_in && action_in[1]) begin
						wave_out <= action_in[0];
					end
				end
				CLS_FAST: begin
					if (action_in[1]) begin
						if (at_top_in) begin
							wave_out <= ~action_in[0];
						end else if (match_in) begin
							wave_out <= action_in[0];
						end
					end else if (action_in[0] && toggle_ok_in && match_in) begin
						wave_out <= ~wave_out;
					end
				end
				CLS_DUAL: begin
					if (action_in[1] && match_in) begin
						wave_out <= heading_up_in ? action_in[0] : ~action_in[0];
					end else if (action_in[0] && toggle_ok_in && match_in) begin
						wave_out <= ~wave_out;
					end
				end
				default: wave_out <= wave_out;
			endcase
		end
	end

	// ==========================================================
	// pin takeover and driver enable
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			takeover_out <= 1'b0;
			drive_en_out <= 1'b0;
		end else begin
			takeover_out <= |action_in;
			drive_en_out <= connected && dir_in;
		end
	end

endmodule

/* hw/twm_timer16.sv */
// twm_timer16: 16-bit waveform timer with counter, compare buffers and register port
//
// Our own choice: strobed register access.
`timescale 1ns/100ps

// How it works
// - one clock, tick qualifies every step
// - dual-slope frequency mode reloads at bottom
// - nonzero action takes over the pin
// - driver enabled only when direction is output
// - action decoded by mode class
// - non-pwm: off, toggle, clear, set
// - fast pwm toggle: channel a, modes 14/15
// - fast pwm: clear on match, set bottom
// - fast pwm compare at top acts at top
// - dual-slope toggle: channel a, modes 9/11
// - dual-slope: clear up, set down
// - mode from two registers, 13 reserved
// - mode 0: top max, immediate, flag max
// - modes 1-3: fixed top dual slope
// - fast pwm modes: update bottom, flag top
// - clear-on-match modes 4 and 12
// - modes 8/9: reload and flag at bottom
// - modes 10/11: load top, flag bottom
// - clock select picks divider or pin edge
// - dual slope counts up then down
module twm_timer16
	import twm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	// external count pin and port direction bits
	input wire logic ext_clk_pin_in,
	input wire logic dir_a_in,
	input wire logic dir_b_in,
	// waveform pins
	output logic wave_a_out,
	output logic wave_a_oe_out,
	output logic takeover_a_out,
	output logic wave_b_out,
	output logic wave_b_oe_out,
	output logic takeover_b_out,
	// status
	output logic overflow_flag_out
);

	if (ADDR_W != 8) begin : g_addr_chk
		$error("register port address must be 8 bits wide");
	end

	// ==========================================================
	// declarations
	logic [1:0] out_a_action_reg;
	logic [1:0] out_b_action_reg;
	logic [1:0] mode_lo_reg;
	logic [1:0] mode_hi_reg;
	logic [2:0] clock_select_reg;
	logic [15:0] counter_value_reg;
	logic [15:0] capture_value_reg;
	logic [15:0] cmp_a_buf_reg;
	logic [15:0] cmp_b_buf_reg;
	logic [15:0] compare_a_value_reg;
	logic [15:0] compare_b_value_reg;
	logic [15:0] cmp_a_buf_next;
	logic [15:0] cmp_b_buf_next;
	logic [15:0] top_value;
	logic match_a_flag_reg;
	logic match_b_flag_reg;
	twm_dir_e dir_reg;
	logic [3:0] waveform_mode;
	twm_class_e cls;
	twm_top_e top_src;
	twm_point_e upd_pt;
	twm_point_e flag_pt;
	logic count_enable_tick;
	logic at_top;
	logic at_bottom;
	logic heading_up;
	logic reload;
	logic ovf_set;
	logic match_a;
	logic match_b;
	logic wr_wctrl;
	logic wr_sctrl;
	logic wr_cnt_lo;
	logic wr_cnt_hi;
	logic wr_cap_lo;
	logic wr_cap_hi;
	logic wr_cmpa_lo;
	logic wr_cmpa_hi;
	logic wr_cmpb_lo;
	logic wr_cmpb_hi;
	logic wr_status;

	// ==========================================================
	// register port write decode
	assign wr_wctrl = wr_en_in && (addr_in == WAVE_CTRL_ADDR);
	assign wr_sctrl = wr_en_in && (addr_in == SECOND_CTRL_ADDR);
	assign wr_cnt_lo = wr_en_in && (addr_in == CNT_LO_ADDR);
	assign wr_cnt_hi = wr_en_in && (addr_in == CNT_HI_ADDR);
	assign wr_cap_lo = wr_en_in && (addr_in == CAP_LO_ADDR);
	assign wr_cap_hi = wr_en_in && (addr_in == CAP_HI_ADDR);
	assign wr_cmpa_lo = wr_en_in && (addr_in == CMPA_LO_ADDR);
	assign wr_cmpa_hi = wr_en_in && (addr_in == CMPA_HI_ADDR);
	assign wr_cmpb_lo = wr_en_in && (addr_in == CMPB_LO_ADDR);
	assign wr_cmpb_hi = wr_en_in && (addr_in == CMPB_HI_ADDR);
	assign wr_status = wr_en_in && (addr_in == STATUS_ADDR);

	// ==========================================================
	// waveform control register
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_a_action_reg <= ACT_RESET;
			out_b_action_reg <= ACT_RESET;
			mode_lo_reg <= MODE_RESET;
		end else if (wr_wctrl) begin
			out_a_action_reg <= wr_data_in[ACT_A_POS +: 2];
			out_b_action_reg <= wr_data_in[ACT_B_POS +: 2];
			mode_lo_reg <= wr_data_in[MODE_LO_POS +: 2];
		end
	end

	// ==========================================================
	// second control register: upper mode bits and clock select
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_hi_reg <= MODE_RESET;
			clock_select_reg <= CSEL_RESET;
		end else if (wr_sctrl) begin
			mode_hi_reg <= wr_data_in[MODE_HI_POS +: 2];
			clock_select_reg <= wr_data_in[CSEL_POS +: 3];
		end
	end

	// ==========================================================
	// mode decoding
	// four-bit mode assembly
	assign waveform_mode = {mode_hi_reg, mode_lo_reg};
	assign cls = mode_class(waveform_mode);
	assign top_src = top_source(waveform_mode);
	assign upd_pt = update_point(waveform_mode);
	assign flag_pt = flag_point(waveform_mode);

	// ==========================================================
	// count-enable tick
	// clock select
	twm_prescaler u_prescaler (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.clock_select_in(clock_select_reg),
		.ext_pin_in(ext_clk_pin_in),
		.tick_out(count_enable_tick)
	);

	// ==========================================================
	// top value and counter position
	always_comb begin
		unique case (top_src)
			TSRC_FIXED: top_value = fixed_top(waveform_mode);
			TSRC_CAPTURE: top_value = capture_value_reg;
			TSRC_CMPA: top_value = compare_a_value_reg;
			default: top_value = TOP_MAX;
		endcase
	end

	assign at_top = (counter_value_reg == top_value);
	assign at_bottom = (counter_value_reg == BOTTOM);
	// direction of the next step, so compare at either end is unambiguous
	assign heading_up = at_bottom ? 1'b1 : (at_top ? 1'b0 : (dir_reg == DIR_UP));

	// ==========================================================
	// counter
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			counter_value_reg <= WORD_RESET;
		end else if (wr_cnt_lo) begin
			counter_value_reg <= set_byte(counter_value_reg, 1'b0, wr_data_in);
		end else if (wr_cnt_hi) begin
			counter_value_reg <= set_byte(counter_value_reg, 1'b1, wr_data_in);
		end else if (count_enable_tick) begin
			if (cls == CLS_DUAL) begin
				// up to top, down to bottom
				if (heading_up) begin
					counter_value_reg <= counter_value_reg + 16'h0001;
				end else begin
					counter_value_reg <= counter_value_reg - 16'h0001;
				end
			end else if (at_top) begin
				counter_value_reg <= BOTTOM;
			end else begin
				counter_value_reg <= counter_value_reg + 16'h0001;
			end
		end
	end

	// ==========================================================
	// count direction
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dir_reg <= DIR_UP;
		end else if (cls != CLS_DUAL) begin
			dir_reg <= DIR_UP;
		end else if (count_enable_tick) begin
			dir_reg <= heading_up ? DIR_UP : DIR_DOWN;
		end
	end

	// ==========================================================
	// capture value, written by software and used as top
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			capture_value_reg <= WORD_RESET;
		end else if (wr_cap_lo) begin
			capture_value_reg <= set_byte(capture_value_reg, 1'b0, wr_data_in);
		end else if (wr_cap_hi) begin
			capture_value_reg <= set_byte(capture_value_reg, 1'b1, wr_data_in);
		end
	end

	// ==========================================================
	// compare buffers, always written by software
	always_comb begin
		cmp_a_buf_next = cmp_a_buf_reg;
		cmp_b_buf_next = cmp_b_buf_reg;
		if (wr_cmpa_lo) begin
			cmp_a_buf_next = set_byte(cmp_a_buf_reg, 1'b0, wr_data_in);
		end
		if (wr_cmpa_hi) begin
			cmp_a_buf_next = set_byte(cmp_a_buf_reg, 1'b1, wr_data_in);
		end
		if (wr_cmpb_lo) begin
			cmp_b_buf_next = set_byte(cmp_b_buf_reg, 1'b0, wr_data_in);
		end
		if (wr_cmpb_hi) begin
			cmp_b_buf_next = set_byte(cmp_b_buf_reg, 1'b1, wr_data_in);
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmp_a_buf_reg <= WORD_RESET;
			cmp_b_buf_reg <= WORD_RESET;
		end else begin
			cmp_a_buf_reg <= cmp_a_buf_next;
			cmp_b_buf_reg <= cmp_b_buf_next;
		end
	end

	// ==========================================================
	// reload point of the active compare values
	always_comb begin
		unique case (upd_pt)
			PT_TOP: reload = count_enable_tick && at_top;
			PT_BOTTOM: begin
				if (cls == CLS_DUAL) begin
					reload = count_enable_tick && at_bottom;
				end else begin
					reload = count_enable_tick && at_top;
				end
			end
			default: reload = 1'b0;
		endcase
	end

	// ==========================================================
	// active compare values
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			compare_a_value_reg <= WORD_RESET;
			compare_b_value_reg <= WORD_RESET;
		end else if (upd_pt == PT_NOW) begin
			compare_a_value_reg <= cmp_a_buf_next;
			compare_b_value_reg <= cmp_b_buf_next;
		end else if (reload) begin
			compare_a_value_reg <= cmp_a_buf_reg;
			compare_b_value_reg <= cmp_b_buf_reg;
		end
	end

	// ==========================================================
	// overflow and compare match events
	always_comb begin
		unique case (flag_pt)
			PT_MAX: ovf_set = count_enable_tick && (counter_value_reg == TOP_MAX);
			PT_TOP: ovf_set = count_enable_tick && at_top;
			PT_BOTTOM: ovf_set = count_enable_tick && at_bottom && (dir_reg == DIR_DOWN);
			default: ovf_set = 1'b0;
		endcase
	end

	assign match_a = count_enable_tick && (counter_value_reg == compare_a_value_reg);
	assign match_b = count_enable_tick && (counter_value_reg == compare_b_value_reg);

	// ==========================================================
	// status flags, write one to clear, a new event wins
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			overflow_flag_out <= 1'b0;
			match_a_flag_reg <= 1'b0;
			match_b_flag_reg <= 1'b0;
		end else begin
			overflow_flag_out <= ovf_set ||
				(overflow_flag_out && !(wr_status && wr_data_in[ST_OVF_POS]));
			match_a_flag_reg <= match_a ||
				(match_a_flag_reg && !(wr_status && wr_data_in[ST_MATCH_A_POS]));
			match_b_flag_reg <= match_b ||
				(match_b_flag_reg && !(wr_status && wr_data_in[ST_MATCH_B_POS]));
		end
	end

	// ==========================================================
	// read data, valid only in the cycle after the strobe
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else if (!rd_en_in) begin
			rd_data_out <= 8'h00;
		end else begin
			unique case (addr_in)
				WAVE_CTRL_ADDR: rd_data_out <= {out_a_action_reg, out_b_action_reg,
					2'b00, mode_lo_reg};
				SECOND_CTRL_ADDR: rd_data_out <= {3'b000, mode_hi_reg, clock_select_reg};
				CNT_LO_ADDR: rd_data_out <= counter_value_reg[7:0];
				CNT_HI_ADDR: rd_data_out <= counter_value_reg[15:8];
				CAP_LO_ADDR: rd_data_out <= capture_value_reg[7:0];
				CAP_HI_ADDR: rd_data_out <= capture_value_reg[15:8];
				CMPA_LO_ADDR: rd_data_out <= cmp_a_buf_reg[7:0];
				CMPA_HI_ADDR: rd_data_out <= cmp_a_buf_reg[15:8];
				CMPB_LO_ADDR: rd_data_out <= cmp_b_buf_reg[7:0];
				CMPB_HI_ADDR: rd_data_out <= cmp_b_buf_reg[15:8];
				STATUS_ADDR: rd_data_out <= {5'b00000, match_b_flag_reg,
					match_a_flag_reg, overflow_flag_out};
				default: rd_data_out <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// waveform channels; channel b never gets toggle permission in pwm
	twm_wave_channel u_chan_a (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.tick_in(count_enable_tick),
		.match_in(match_a),
		.at_top_in(at_top),
		.heading_up_in(heading_up),
		.action_in(out_a_action_reg),
		.cls_in(cls),
		.toggle_ok_in(toggle_allowed(waveform_mode)),
		.dir_in(dir_a_in),
		.wave_out(wave_a_out),
		.drive_en_out(wave_a_oe_out),
		.takeover_out(takeover_a_out)
	);

	twm_wave_channel u_chan_b (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.tick_in(count_enable_tick),
		.match_in(match_b),
		.at_top_in(at_top),
		.heading_up_in(heading_up),
		.action_in(out_b_action_reg),
		.cls_in(cls),
		.toggle_ok_in(cls == CLS_NONPWM),
		.dir_in(dir_b_in),
		.wave_out(wave_b_out),
		.drive_en_out(wave_b_oe_out),
		.takeover_out(takeover_b_out)
	);

endmodule

/* dv/twm_timer16_checker.sv */
// twm_timer16_checker: port assertions of the waveform timer
`timescale 1ns/100ps
module twm_timer16_checker
	import twm_pkg::*;
#(parameter int ADDR_W = 8) (
	// watched ports
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [7:0] rd_data_out,
	input wire logic dir_a_in,
	input wire logic dir_b_in,
	input wire logic wave_a_out,
	input wire logic wave_a_oe_out,
	input wire logic takeover_a_out,
	input wire logic wave_b_oe_out,
	input wire logic overflow_flag_out
);
	// ==========================================================
	// properties
	default clocking dc @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);
	a_rd_idle_zero: assert property (!$past(rd_en_in) |-> rd_data_out == 8'h00)
		else $error("read data outside read slot");
	a_rsvd_bits_zero: assert property ($past(rd_en_in) && $past(addr_in) == WAVE_CTRL_ADDR
		|-> rd_data_out[3:2] == 2'b00) else $error("reserved control bits not zero");
	a_hole_reads_zero: assert property ($past(rd_en_in) && $past(addr_in) == 8'h90
		|-> rd_data_out == 8'h00) else $error("unmapped read not zero");
	a_oe_a_dir: assert property (wave_a_oe_out |-> $past(dir_a_in))
		else $error("pin a driven while input");
	a_oe_b_dir: assert property (wave_b_oe_out |-> $past(dir_b_in))
		else $error("pin b driven while input");
	a_take_by_write: assert property ($changed(takeover_a_out)
		|-> $past(wr_en_in) || $past(wr_en_in, 2)) else $error("takeover moved without write");
	a_ovf_clear_write: assert property ($fell(overflow_flag_out) |-> $past(wr_en_in) &&
		$past(addr_in) == STATUS_ADDR && ($past(wr_data_in) & 8'h01) != 8'h00)
		else $error("overflow cleared without write");
	a_ovf_status_bit: assert property ($past(rd_en_in) && $past(addr_in) == STATUS_ADDR
		|-> rd_data_out[0] == $past(overflow_flag_out)) else $error("status bit 0 mismatch");
	// main scenarios reached
	cover property ($rose(overflow_flag_out));
	cover property ($rose(wave_a_out) && wave_a_oe_out);
	cover property ($fell(wave_b_oe_out));
endmodule
bind twm_timer16 twm_timer16_checker #(.ADDR_W(ADDR_W)) i_twm_timer16_checker (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .dir_a_in(dir_a_in),
	.dir_b_in(dir_b_in), .wave_a_out(wave_a_out), .wave_a_oe_out(wave_a_oe_out),
	.takeover_a_out(takeover_a_out), .wave_b_oe_out(wave_b_oe_out),
	.overflow_flag_out(overflow_flag_out));

/* dv/twm_pin_load.sv */
// twm_pin_load: load on the waveform pins, pulled up when undriven
`timescale 1ns/100ps
module twm_pin_load (
	// pin drivers
	input wire logic wave_a_in,
	input wire logic oe_a_in,
	input wire logic wave_b_in,
	input wire logic oe_b_in,
	// pin levels
	output logic pin_a_out,
	output logic pin_b_out
);
	// ==========================================================
	// pull-up when released
	assign pin_a_out = oe_a_in ? wave_a_in : 1'b1;
	assign pin_b_out = oe_b_in ? wave_b_in : 1'b1;
endmodule

/* dv/twm_timer16_tb.sv */
// twm_timer16_tb: self-checking bench of the waveform timer
`timescale 1ns/100ps
module twm_timer16_tb;
	import twm_pkg::*;
	logic clk, rst, wr, rd, ext, da, db, wa, oa, ta, wb, ob, tb, ovf, pa, pb;
	logic [7:0] ad, wd, rdd, d;
	logic [31:0] rnd;
	int failures, cmp_count, hi, lo;
	twm_timer16 i_twm_timer16 (.ref_clk_in(clk), .rst_in(rst), .addr_in(ad), .wr_data_in(wd),
		.wr_en_in(wr), .rd_en_in(rd), .rd_data_out(rdd), .ext_clk_pin_in(ext), .dir_a_in(da),
		.dir_b_in(db), .wave_a_out(wa), .wave_a_oe_out(oa), .takeover_a_out(ta),
		.wave_b_out(wb), .wave_b_oe_out(ob), .takeover_b_out(tb), .overflow_flag_out(ovf));
	twm_pin_load i_twm_pin_load (.wave_a_in(wa), .oe_a_in(oa), .wave_b_in(wb), .oe_b_in(ob),
		.pin_a_out(pa), .pin_b_out(pb));
	// clock and random count pin
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) ext <= rnd[3];
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected high or low length: class 0 non-pwm, 1 fast, 2 dual
	function automatic int exp_len(input int c, input int a, input int cm, input int tp,
		input bit h);
		int per;
		int hv;
		per = (c == 2) ? 2 * tp : tp + 1;
		hv = (c == 2) ? 2 * cm : cm + 1;
		if (a == 1) return per;
		if (a == 3) hv = per - hv;
		return h ? hv : per - hv;
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		ad <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		ad <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdd;
	endtask
	// high then low run lengths on a pin, after one settling period
	task automatic meas(input logic ch);
		int n;
		for (int i = 0; i < 4; i++) begin
			n = 0;
			while ((ch ? pb : pa) === (i % 2 == 0) && n < 3000) begin
				@(negedge clk);
				n++;
			end
			if (i == 2) hi = n;
			lo = n;
		end
	endtask
	task automatic run(input logic [3:0] m, input int c, input logic [1:0] a, input logic ch,
		input logic [7:0] cm, input logic [7:0] tp, input logic on);
		wreg(SECOND_CTRL_ADDR, 8'h00);
		wreg(WAVE_CTRL_ADDR, 8'h00);
		wreg(CNT_LO_ADDR, 8'h00);
		wreg(CNT_HI_ADDR, 8'h00);
		wreg(CMPA_LO_ADDR, ch ? tp : cm);
		wreg(CMPB_LO_ADDR, cm);
		wreg(CAP_LO_ADDR, tp);
		da <= 1'b0;
		db <= 1'b0;
		wreg(SECOND_CTRL_ADDR, {3'h0, m[3:2], 3'h1});
		wreg(WAVE_CTRL_ADDR, ch ? {2'h0, a, 2'h0, m[1:0]} : {a, 4'h0, m[1:0]});
		repeat (3) @(negedge clk);
		chk(16'(ch ? ob : oa), 16'h0000);
		chk(16'(ch ? tb : ta), 16'h0001);
		@(posedge clk);
		da <= 1'b1;
		db <= 1'b1;
		repeat (3) @(negedge clk);
		chk(16'(ch ? ob : oa), 16'(on));
		if (on) begin
			meas(ch);
			chk(16'(hi), 16'(exp_len(c, a, cm, tp, 1)));
			chk(16'(lo), 16'(exp_len(c, a, cm, tp, 0)));
		end
		$display("mode %0d action %0d channel %0d done", m, a, ch);
	endtask
	task automatic stop_test;
		$display("%0d compares, %0d mismatches", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#(25 * 60000);
		failures++;
		stop_test;
	end
	initial begin
		{rst, wr, rd, da, db} = 5'b10000;
		ad = 8'h00;
		wd = 8'h00;
		rnd = 32'hdd70;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rreg(8'h90);
		chk(16'(d), 16'h0000);
		wreg(CNT_HI_ADDR, 8'hff);
		wreg(CNT_LO_ADDR, 8'hf0);
		wreg(SECOND_CTRL_ADDR, 8'h01);
		repeat (30) @(negedge clk);
		rreg(STATUS_ADDR);
		chk(16'(d[0] & ovf), 16'h0001);
		wreg(STATUS_ADDR, 8'h01);
		@(negedge clk);
		chk(16'(ovf), 16'h0000);
		// divide by 8: any 64-cycle window holds exactly 8 ticks
		wreg(SECOND_CTRL_ADDR, 8'h02);
		rreg(CNT_LO_ADDR);
		lo = d;
		repeat (62) @(negedge clk);
		rreg(CNT_LO_ADDR);
		chk(16'(8'(d - lo[7:0])), 16'h0008);
		$display("overflow test done");
		repeat (8) begin
			rnd = lfsr(rnd);
			wreg(WAVE_CTRL_ADDR, rnd[7:0]);
			wreg(SECOND_CTRL_ADDR, rnd[15:8]);
			rreg(WAVE_CTRL_ADDR);
			chk(16'(d), 16'(rnd[7:0] & 8'hf3));
			rreg(SECOND_CTRL_ADDR);
			chk(16'(d), 16'(rnd[15:8] & 8'h1f));
		end
		$display("readback test done");
		run(4'h4, 0, 2'h1, 1'b0, 8'h13, 8'h13, 1'b1);
		run(4'hc, 0, 2'h1, 1'b1, 8'h13, 8'h13, 1'b1);
		run(4'h5, 1, 2'h2, 1'b0, 8'h40, 8'hff, 1'b1);
		run(4'h6, 1, 2'h1, 1'b0, 8'h40, 8'hff, 1'b0);
		run(4'he, 1, 2'h1, 1'b0, 8'h3f, 8'h3f, 1'b1);
		run(4'hf, 1, 2'h1, 1'b1, 8'h20, 8'h20, 1'b0);
		run(4'h1, 2, 2'h2, 1'b0, 8'h40, 8'hff, 1'b1);
		run(4'ha, 2, 2'h3, 1'b1, 8'h40, 8'hff, 1'b1);
		run(4'h8, 2, 2'h2, 1'b1, 8'h40, 8'hff, 1'b1);
		run(4'h9, 2, 2'h1, 1'b0, 8'h20, 8'h20, 1'b1);
		run(4'h3, 2, 2'h1, 1'b0, 8'h40, 8'hff, 1'b0);
		stop_test;
	end
endmodule
